// ### tw_master.sv
// two-wire master transmitter with apb register access
// Operation
// - start first; address write/read bit picks mode
// - unit works only while enable set
// - start waits until bus is free
// - start sent: flag set, code 0x08
// - writing one to flag clears it
// - address sent: flag, code 0x18/0x20/0x38
// - 0x18 address acked, 0x20 not acked
// - 0x28 data acked, 0x30 not acked
// - data write with flag low: ignored, collision
// - plain clear sends byte, samples acknowledge
// - clear with start sends repeated start
// - clear with stop: stop, stop bit cleared
// - clear with both: stop then start
// - repeated start reports 0x10, keeps bus
// - in 0x10 read address enters receive mode
// - arbitration lost 0x38; clear releases bus
// - in 0x38 clear with start restarts
// - flag set holds bus suspended
//
// Added by the designer: the address map and the APB slave port.
`default_nettype none
module tw_master (
    // clock and reset
    input  wire logic        clock,
    input  wire logic        rst_b,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // two-wire bus, open drain
    input  wire logic        scl_in,
    output logic             scl_out,
    output logic             scl_oe_b,
    input  wire logic        sda_in,
    output logic             sda_out,
    output logic             sda_oe_b,
    // events
    output logic             irq,
    output logic             rx_mode_active
);
    import tw_pkg::*;
    // ------------------------------------------------------------
    // state record
    // ------------------------------------------------------------
    typedef struct packed {
        tw_phase_t   phase;    // sequencer phase
        logic [1:0]  q;        // quarter within a bit
        logic [3:0]  bitn;     // bit index, 8 is ack
        logic [7:0]  shreg;    // shift register
        logic        flag;     // step_done_flag
        logic        ack_en;   // ack_enable, stored only
        logic        start_column;      // start_request
        logic        stop_column;      // stop_request
        logic        wc;       // write_collision_flag
        logic        en;       // interface_enable
        logic        ie;       // step_irq_enable
        logic [1:0]  presc;    // prescaler bits, stored only
        logic [4:0]  code;     // status code bits 7..3
        logic [7:0]  data;     // bus_data_register
        logic        scl_low;  // pulling clock low
        logic        sda_low;  // pulling data low
        logic        rep;      // start is a repeated one
        logic        addr_ph;  // next byte is an address
        logic        owner;    // we own the bus
        logic        stop_sta; // start follows stop
        logic        rx_mode;  // address with read sent
        logic        busy;     // bus held by someone
        logic        sda_prev; // last clean data level
        logic [31:0] rdata;    // registered read data
        logic        serr;     // registered error answer
    } tw_state_t;
    tw_state_t s, next_s;
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    logic scl_s;      // clean clock level
    logic sda_s;      // clean data level
    logic tick;       // quarter-bit pulse
    logic acc_wr;     // write takes effect
    logic wr_ctrl;    // control written
    logic clr_flag;   // flag cleared this cycle
    logic set_flag;   // flag set this cycle
    logic [7:0] wb;   // written byte
    logic [7:0] ctrl_rd;
    logic [7:0] stat_rd;
    tw_sync u_scl (
        .clock (clock),
        .rst_b (rst_b),
        .pin   (scl_in),
        .level (scl_s)
    );
    tw_sync u_sda (
        .clock (clock),
        .rst_b (rst_b),
        .pin   (sda_in),
        .level (sda_s)
    );
    tw_tick u_tick (
        .clock (clock),
        .rst_b (rst_b),
        .tick  (tick)
    );
    assign wb      = pwdata[7:0];
    assign acc_wr  = psel & penable & pwrite;
    assign wr_ctrl = acc_wr & (paddr == ADDR_CONTROL);
    assign clr_flag = wr_ctrl & wb[BIT_FLAG];
    // control and status as software sees them
    assign ctrl_rd = {s.flag, s.ack_en, s.start_column, s.stop_column, s.wc, s.en,
                      1'b0, s.ie};
    assign stat_rd = {s.code, 1'b0, s.presc};
    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        next_s   = s;
        set_flag = 1'b0;
        // apb setup: latch read data for the access phase
        if (psel && !penable) begin
            next_s.serr  = 1'b0;
            next_s.rdata = 32'h0000_0000;
            unique case (paddr)
                ADDR_CONTROL: next_s.rdata = {24'h000000, ctrl_rd};
                ADDR_STATUS:  next_s.rdata = {24'h000000, stat_rd};
                ADDR_DATA:    next_s.rdata = {24'h000000, s.data};
                default:      next_s.serr  = 1'b1; // unmapped
            endcase
        end
        // control write, flag handled below
        if (wr_ctrl) begin
            next_s.ack_en = wb[BIT_ACKEN];
            next_s.start_column    = wb[BIT_STA];
            next_s.stop_column    = wb[BIT_STO];
            next_s.en     = wb[BIT_EN];
            next_s.ie     = wb[BIT_IE];
        end
        // status write keeps only the prescaler bits
        if (acc_wr && paddr == ADDR_STATUS) begin
            next_s.presc = wb[PRESC_MSB:0];
        end
        // data write only while flag high
        if (acc_wr && paddr == ADDR_DATA) begin
            if (s.flag) begin
                next_s.data = wb;
                next_s.wc   = 1'b0;
            end else begin
                next_s.wc   = 1'b1;
            end
        end
        // bus busy watch: start and stop seen on the wires
        next_s.sda_prev = sda_s;
        if (scl_s && s.sda_prev && !sda_s) begin
            next_s.busy = 1'b1;
        end else if (scl_s && !s.sda_prev && sda_s) begin
            next_s.busy = 1'b0;
        end
        // sequencer
        unique case (s.phase)
            PH_IDLE: begin
                next_s.scl_low = 1'b0;
                next_s.sda_low = 1'b0;
                if (s.en && s.start_column && !s.flag) begin
                    next_s.phase = PH_FREE;
                    next_s.rep   = 1'b0;
                end
            end
            PH_FREE: begin
                if (!s.busy) begin
                    next_s.phase = PH_START;
                    next_s.q     = 2'h0;
                end
            end
            PH_START: begin
                if (tick) begin
                    unique case (s.q)
                        2'h0: begin
                            next_s.sda_low = 1'b0;
                            next_s.q       = 2'h1;
                        end
                        2'h1: begin
                            next_s.scl_low = 1'b0;
                            if (scl_s && sda_s) begin
                                next_s.q = 2'h2;
                            end
                        end
                        2'h2: begin
                            next_s.sda_low = 1'b1; // start edge
                            next_s.q       = 2'h3;
                        end
                        2'h3: begin
                            next_s.scl_low = 1'b1;
                            next_s.owner   = 1'b1;
                            next_s.addr_ph = 1'b1;
                            next_s.rx_mode = 1'b0;
                            next_s.code    = s.rep ?
                                CODE_RSTART[7:CODE_LSB] :
                                CODE_START[7:CODE_LSB];
                            set_flag       = 1'b1;
                            next_s.phase   = PH_HOLD;
                        end
                    endcase
                end
            end
            PH_BIT: begin
                if (tick) begin
                    unique case (s.q)
                        2'h0: begin
                            next_s.sda_low = (s.bitn == 4'(LAST_BIT))
                                ? 1'b0 : !s.shreg[7];
                            next_s.q = 2'h1;
                        end
                        2'h1: begin
                            next_s.scl_low = 1'b0;
                            next_s.q       = 2'h2;
                        end
                        2'h2: begin
                            // wait out a slave holding the clock
                            if (scl_s) begin
                                next_s.q = 2'h3;
                                if (s.bitn == 4'(LAST_BIT)) begin
                                    // ack in bit 0, r/w bit in bit 1
                                    next_s.shreg = {s.shreg[6:0], sda_s};
                                end else if (!s.sda_low && !sda_s) begin
                                    // lost arbitration: let go
                                    next_s.scl_low = 1'b0;
                                    next_s.owner   = 1'b0;
                                    next_s.code    = CODE_ARB[7:CODE_LSB];
                                    set_flag       = 1'b1;
                                    next_s.phase   = PH_HOLD;
                                end else begin
                                    next_s.shreg = {s.shreg[6:0], sda_s};
                                end
                            end
                        end
                        2'h3: begin
                            next_s.scl_low = 1'b1;
                            next_s.q       = 2'h0;
                            if (s.bitn == 4'(LAST_BIT)) begin
                                set_flag       = 1'b1;
                                next_s.phase   = PH_HOLD;
                                next_s.addr_ph = 1'b0;
                                if (s.addr_ph && s.shreg[1]) begin
                                    next_s.rx_mode = 1'b1;
                                    next_s.code = s.shreg[0] ?
                                        CODE_AR_NAK[7:CODE_LSB] :
                                        CODE_AR_ACK[7:CODE_LSB];
                                end else if (s.addr_ph) begin
                                    next_s.code = s.shreg[0] ?
                                        CODE_AW_NAK[7:CODE_LSB] :
                                        CODE_AW_ACK[7:CODE_LSB];
                                end else begin
                                    next_s.code = s.shreg[0] ?
                                        CODE_DT_NAK[7:CODE_LSB] :
                                        CODE_DT_ACK[7:CODE_LSB];
                                end
                            end else begin
                                next_s.bitn = s.bitn + 4'h1;
                            end
                        end
                    endcase
                end
            end
            PH_STOP: begin
                if (tick) begin
                    unique case (s.q)
                        2'h0: begin
                            next_s.sda_low = 1'b1;
                            next_s.q       = 2'h1;
                        end
                        2'h1: begin
                            next_s.scl_low = 1'b0;
                            if (scl_s) begin
                                next_s.q = 2'h2;
                            end
                        end
                        2'h2: begin
                            next_s.sda_low = 1'b0; // stop edge
                            next_s.q       = 2'h3;
                        end
                        2'h3: begin
                            next_s.stop_column   = 1'b0;
                            next_s.owner = 1'b0;
                            next_s.rep   = 1'b0;
                            next_s.q     = 2'h0;
                            next_s.phase = s.stop_sta ? PH_FREE : PH_IDLE;
                        end
                    endcase
                end
            end
            PH_HOLD: begin
                // suspended: clock held low while we own it
                if (clr_flag && wb[BIT_EN]) begin
                    next_s.q = 2'h0;
                    if (!s.owner) begin
                        next_s.sda_low = 1'b0;
                        next_s.rep     = 1'b0;
                        next_s.phase   = wb[BIT_STA] ?
                            PH_FREE : PH_IDLE;
                    end else if (wb[BIT_STO]) begin
                        next_s.stop_sta = wb[BIT_STA];
                        next_s.phase    = PH_STOP;
                    end else if (wb[BIT_STA]) begin
                        next_s.rep   = 1'b1;
                        next_s.phase = PH_START;
                    end else if (!s.rx_mode) begin
                        next_s.shreg = s.data;
                        next_s.bitn  = 4'h0;
                        next_s.phase = PH_BIT;
                    end
                end
            end
            default: begin
                next_s.phase = PH_IDLE;
            end
        endcase
        // flag: a set in the same cycle beats the clear
        next_s.flag = (s.flag & !clr_flag) | set_flag;
        if (clr_flag && !set_flag) begin
            next_s.code = CODE_IDLE[7:CODE_LSB];
        end
        // disabled unit lets go of the bus at once
        if (!next_s.en) begin
            next_s.phase   = PH_IDLE;
            next_s.scl_low = 1'b0;
            next_s.sda_low = 1'b0;
            next_s.owner   = 1'b0;
            next_s.flag    = 1'b0;
            next_s.code    = CODE_IDLE[7:CODE_LSB];
        end
    end
    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            s          <= '0;
            s.phase    <= PH_IDLE;
            s.code     <= CODE_IDLE[7:CODE_LSB];
            s.presc    <= RESET_PRESC;
            s.sda_prev <= 1'b1;
        end else begin
            s <= next_s;
        end
    end
    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign prdata   = s.rdata;
    assign pready   = 1'b1;
    assign pslverr  = s.serr & psel & penable;
    assign scl_out  = 1'b0;
    assign sda_out  = 1'b0;
    assign scl_oe_b = !s.scl_low;
    assign sda_oe_b = !s.sda_low;
    assign irq      = s.flag & s.ie;
    assign rx_mode_active = s.rx_mode;
endmodule : tw_master
`default_nettype wire

// ### tw_pkg.sv
// constants and types shared by the two-wire master transmitter
`default_nettype none
package tw_pkg;
    // ------------------------------------------------------------
    // register map, byte addresses
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CONTROL = 8'h00; // two_wire_control
    localparam logic [7:0] ADDR_STATUS  = 8'h04; // bus_status_register
    localparam logic [7:0] ADDR_DATA    = 8'h08; // bus_data_register
    // ------------------------------------------------------------
    // control field positions
    // ------------------------------------------------------------
    localparam int BIT_FLAG  = 7; // step_done_flag
    localparam int BIT_ACKEN = 6; // ack_enable
    localparam int BIT_STA   = 5; // start_request
    localparam int BIT_STO   = 4; // stop_request
    localparam int BIT_WC    = 3; // write_collision_flag
    localparam int BIT_EN    = 2; // interface_enable
    localparam int BIT_IE    = 0; // step_irq_enable
    // ------------------------------------------------------------
    // status field positions and codes
    // ------------------------------------------------------------
    localparam int CODE_LSB  = 3; // code in bits 7..3
    localparam int PRESC_MSB = 1; // prescaler bits 1..0
    localparam logic [7:0] CODE_START  = 8'h08;
    localparam logic [7:0] CODE_RSTART = 8'h10;
    localparam logic [7:0] CODE_AW_ACK = 8'h18;
    localparam logic [7:0] CODE_AW_NAK = 8'h20;
    localparam logic [7:0] CODE_DT_ACK = 8'h28;
    localparam logic [7:0] CODE_DT_NAK = 8'h30;
    localparam logic [7:0] CODE_ARB    = 8'h38;
    localparam logic [7:0] CODE_AR_ACK = 8'h40;
    localparam logic [7:0] CODE_AR_NAK = 8'h48;
    localparam logic [7:0] CODE_IDLE   = 8'hf8;
    localparam logic [7:0] RESET_CTRL  = 8'h00;
    localparam logic [1:0] RESET_PRESC = 2'h0;
    // ------------------------------------------------------------
    // timing: one quarter of a bus bit
    // ------------------------------------------------------------
    localparam int CLK_NS     = 10;
    localparam int QUARTER_NS = 2500;
    localparam int QUARTER_CYC = (QUARTER_NS + CLK_NS - 1) / CLK_NS;
    localparam int LAST_BIT   = 8; // bit 8 is the acknowledge slot
    // ------------------------------------------------------------
    // sequencer phases
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        PH_IDLE, PH_FREE, PH_START, PH_BIT, PH_STOP, PH_HOLD
    } tw_phase_t;
endpackage : tw_pkg
`default_nettype wire

// ### tw_sync.sv
// three-stage synchroniser for one pin, changes when stages agree
`default_nettype none
module tw_sync (
    // clock and reset
    input  wire logic clock,
    input  wire logic rst_b,
    // pin in, clean level out
    input  wire logic pin,
    output logic      level
);
    import tw_pkg::*;
    typedef struct packed {
        logic f1;   // first stage, read only by f2
        logic f2;   // second stage
        logic f3;   // third stage
        logic lvl;  // accepted level
    } tw_sync_t;
    tw_sync_t s, next_s;
    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        next_s    = s;
        next_s.f1 = pin;
        next_s.f2 = s.f1;
        next_s.f3 = s.f2;
        if (s.f2 == s.f3) begin // accept once two stages agree
            next_s.lvl = s.f3;
        end
    end
    // state register, idle bus is high
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            s <= '1;
        end else begin
            s <= next_s;
        end
    end
    assign level = s.lvl;
endmodule : tw_sync
`default_nettype wire

// ### tw_tick.sv
// divider giving a one-cycle pulse every quarter bit
`default_nettype none
module tw_tick (
    // clock and reset
    input  wire logic clock,
    input  wire logic rst_b,
    // quarter-bit pulse
    output logic      tick
);
    import tw_pkg::*;
    localparam logic [15:0] TOP = 16'(QUARTER_CYC - 1);
    typedef struct packed {
        logic [15:0] cnt; // cycles into the quarter
        logic        pls; // pulse register
    } tw_tick_t;
    tw_tick_t s, next_s;
    // ------------------------------------------------------------
    // count and pulse
    // ------------------------------------------------------------
    always_comb begin
        next_s     = s;
        next_s.pls = (s.cnt == TOP);
        next_s.cnt = (s.cnt == TOP) ? 16'h0000 : s.cnt + 16'h0001;
    end
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end
    assign tick = s.pls;
endmodule : tw_tick
`default_nettype wire

// ### tw_master_assertions.sv
// concurrent checks on the two-wire master ports
`default_nettype none
module tw_master_assertions (
    // clock and reset
    input wire logic        clock,
    input wire logic        rst_b,
    // apb slave side
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // bus pins and events
    input wire logic        scl_in,
    input wire logic        scl_out,
    input wire logic        scl_oe_b,
    input wire logic        sda_in,
    input wire logic        sda_out,
    input wire logic        sda_oe_b,
    input wire logic        irq,
    input wire logic        rx_mode_active
);
    timeunit 1ns;
    timeprecision 1ps;
    import tw_pkg::*;
    logic wr_ctl; // control write taking effect
    assign wr_ctl = psel && penable && pwrite && paddr == ADDR_CONTROL;
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);
    suspend_hold_a: assert property (irq && $past(irq) |->
        $stable(sda_oe_b) && $stable(scl_oe_b)) else $error("bus moved");
    idle_code_a: assert property (psel && penable && !pwrite &&
        paddr == ADDR_STATUS && $past(irq) |-> prdata[7:3] != 5'h1f)
        else $error("idle code with flag set");
    flag_clear_a: assert property (wr_ctl && pwdata[7] && irq
        |-> ##[1:3] !irq) else $error("flag not cleared");
    release_off_a: assert property (wr_ctl && !pwdata[BIT_EN] |->
        ##[1:4] (scl_oe_b && sda_oe_b)) else $error("lines not released");
    scl_high_a: assert property ($rose(scl_oe_b) |=> scl_oe_b [*8])
        else $error("short clock high");
    scl_low_a: assert property ($fell(scl_oe_b) |=> !scl_oe_b [*8])
        else $error("short clock low");
    stop_idle_a: assert property ($rose(sda_oe_b) && scl_oe_b &&
        scl_in |=> (sda_oe_b && scl_oe_b) [*2]) else $error("stop bad");
    unmapped_a: assert property (psel && penable && paddr > ADDR_DATA
        |-> pslverr && (pwrite || prdata == 32'h0)) else $error("no err");
    irq_seen_c: cover property ($rose(irq));
    stop_seen_c: cover property ($rose(sda_oe_b) && scl_oe_b && scl_in);
    err_seen_c: cover property (psel && penable && pslverr);
endmodule : tw_master_assertions
bind tw_master tw_master_assertions u_chk (
    .clock(clock), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .scl_in(scl_in),
    .scl_out(scl_out), .scl_oe_b(scl_oe_b), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe_b(sda_oe_b), .irq(irq),
    .rx_mode_active(rx_mode_active)
);
`default_nettype wire

// ### tw_slave.sv
// behavioural slave receiver on the two-wire bus
`default_nettype none
module tw_slave (
    // bus wires
    input  wire logic       scl,
    input  wire logic       sda,
    output logic            sda_low,
    // answer choice and captured byte
    input  wire logic       nak,
    output logic [7:0]      last_byte
);
    timeunit 1ns;
    timeprecision 1ps;
    int         cnt;   // clock pulses since start or since the last ack slot
    logic [7:0] sh;    // shift register, msb first
    initial begin
        sda_low   = 1'b0;
        cnt       = 0;
        sh        = 8'h00;
        last_byte = 8'h00;
    end
    // start or repeated start restarts the count
    always @(negedge sda) if (scl) cnt = 0;
    // sample data while clock rises
    always @(posedge scl) begin
        if (cnt < 8) sh = {sh[6:0], sda};
        cnt = cnt + 1;
    end
    // ack slot after eighth bit, then let the line go to the pull-up
    always @(negedge scl) begin
        if (cnt == 8) begin
            last_byte = sh;
            sda_low   = !nak;
        end else if (cnt == 9) begin
            sda_low = 1'b0;
            cnt     = 0;
        end
    end
endmodule : tw_slave
`default_nettype wire

// ### test_two_wire_master_transmit.sv
// self-checking bench for the two-wire master transmitter
`default_nettype none
`define CHECK(what, exp, got) begin samples_checked++; \
    if ((got) !== (exp)) begin fail_count++; \
    $display("mismatch %s expected %h seen %h", what, exp, got); end end
module test_two_wire_master_transmit;
    timeunit 1ns;
    timeprecision 1ps;
    import tw_pkg::*;
    logic        clock, rst_b, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr, last_byte;
    logic [31:0] pwdata, prdata, rd;
    logic        scl_out, scl_oe_b, sda_out, sda_oe_b, irq, rx_mode_active;
    logic        sda_low, nak, err;
    wire         scl, sda; // pulled-up open-drain wires
    int          fail_count, samples_checked;
    assign scl = scl_oe_b | scl_out;
    assign sda = (sda_oe_b | sda_out) & ~sda_low;
    tw_master dut (.clock(clock), .rst_b(rst_b), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .scl_in(scl), .scl_out(scl_out),
        .scl_oe_b(scl_oe_b), .sda_in(sda), .sda_out(sda_out),
        .sda_oe_b(sda_oe_b), .irq(irq), .rx_mode_active(rx_mode_active));
    tw_slave slv (.scl(scl), .sda(sda), .sda_low(sda_low), .nak(nak),
        .last_byte(last_byte));
    always #5 clock = ~clock;
    // one apb transfer, held until pready is seen at an edge
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [7:0] d);
        @(posedge clock);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= {24'h0, d};
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // control write, wait for the flag, compare masked status
    task automatic step(input logic [7:0] ctl, input logic [7:0] code);
        int n;
        n = 0;
        apb(1'b1, ADDR_CONTROL, ctl);
        repeat (3) @(posedge clock);
        while (irq !== 1'b1 && n < 30000) begin
            @(posedge clock);
            n++;
        end
        `CHECK("irq", 1'b1, irq)
        apb(1'b0, ADDR_STATUS, 8'h00);
        `CHECK("status", code, rd[7:0] & 8'hf8)
    endtask : step
    task automatic conclude;
        if (fail_count == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : conclude
    // watchdog against a hung transfer
    initial begin
        repeat (90000) @(posedge clock);
        fail_count++;
        conclude();
    end
    initial begin
        clock = 0; rst_b = 0; psel = 0; penable = 0; pwrite = 0;
        paddr = 0; pwdata = 0; nak = 0; fail_count = 0; samples_checked = 0;
        repeat (6) @(posedge clock);
        rst_b <= 1'b1;
        apb(1'b0, ADDR_STATUS, 8'h00);
        `CHECK("status", CODE_IDLE, rd[7:0])
        apb(1'b1, ADDR_DATA, 8'h55);
        apb(1'b0, ADDR_CONTROL, 8'h00);
        `CHECK("control", 8'h08, rd[7:0])
        apb(1'b0, 8'h0c, 8'h00);
        `CHECK("pslverr", 1'b1, err)
        step(8'ha5, CODE_START);
        apb(1'b1, ADDR_DATA, 8'ha0);
        step(8'h85, CODE_AW_ACK);
        `CHECK("byte", 8'ha0, last_byte)
        nak <= 1'b1;
        apb(1'b1, ADDR_DATA, 8'h5a);
        step(8'h85, CODE_DT_NAK);
        nak <= 1'b0;
        apb(1'b1, ADDR_DATA, 8'h3c);
        step(8'h85, CODE_DT_ACK);
        `CHECK("byte", 8'h3c, last_byte)
        step(8'ha5, CODE_RSTART);
        apb(1'b1, ADDR_DATA, 8'ha1);
        step(8'h85, CODE_AR_ACK);
        `CHECK("rx mode", 1'b1, rx_mode_active)
        apb(1'b1, ADDR_CONTROL, 8'h95);
        repeat (40) begin
            repeat (100) @(posedge clock);
            apb(1'b0, ADDR_CONTROL, 8'h00);
            if (rd[BIT_STO] === 1'b0) break;
        end
        `CHECK("stop bit", 1'b0, rd[BIT_STO])
        `CHECK("bus idle", 2'b11, {scl, sda})
        step(8'ha5, CODE_START);
        step(8'hb5, CODE_START);
        apb(1'b0, ADDR_CONTROL, 8'h00);
        `CHECK("stop bit", 1'b0, rd[BIT_STO])
        // let the held clock low phase outlast its minimum
        repeat (10) @(posedge clock);
        apb(1'b1, ADDR_CONTROL, 8'h00);
        @(posedge clock);
        `CHECK("irq off", 1'b0, irq)
        `CHECK("bus free", 2'b11, {scl, sda})
        conclude();
    end
endmodule : test_two_wire_master_transmit
`default_nettype wire
